// [include/doag_params.svh]
// constants of the data operand address generator: offsets, fields, resets
//----------------------------------------------------------------------------
// Contract
// - inherent instructions compute no data-memory address at all
// - literal taken from the opcode; call/jump carry a 20-bit target
// - byte and bit instructions use opcode low byte as file address
// - access bit 1: bank select register joins the 8-bit address
// - access bit 0: bank select ignored, address lands in access bank
// - full-address move uses both 12-bit addresses unmodified
// - destination bit 1 writes the file register, 0 the working register
// - without destination bit the opcode fixes the implicit destination
// - pointers are special function registers, writable by instructions
// - virtual operands post-inc, post-dec, pre-inc or offset a pointer
// - extended set adds eight two-word instructions, decoded like others
// - in extended mode first and second pointers behave as in core mode
// - indexed offset only when access bit 0 and address at most 5Fh
// - indexed offset adds unsigned file address to third pointer
// - access bit 1 or address 60h and above stay direct in extended mode
// - inherent and literal instructions unchanged by the extended set
// - program memory addressing identical with or without extended set
// - data space size, linear map and register placement unchanged
`ifndef DOAG_PARAMS_SVH
`define DOAG_PARAMS_SVH
`define DOAG_ADDR_W     12
`define DOAG_TGT_W      20
`define DOAG_NPTR       3
`define DOAG_OP_D_BIT   9
`define DOAG_OP_A_BIT   8
`define DOAG_ACC_SPLIT  8'h80
`define DOAG_ACC_LO     4'h0
`define DOAG_ACC_HI     4'hF
`define DOAG_IDX_MAX    8'h5F
`define DOAG_IDX_PTR    2
// virtual operands and pointer bytes: address = {tag, pointer, kind}
`define DOAG_VOP_TAG    7'h7E
`define DOAG_VK_INDIRECT_OPERAND    3'h0
`define DOAG_VK_POSTINC 3'h1
`define DOAG_VK_POSTDEC 3'h2
`define DOAG_VK_PREINC  3'h3
`define DOAG_VK_PLUSW   3'h4
`define DOAG_VK_PTR_LO  3'h5
`define DOAG_VK_PTR_HI  3'h6
`define DOAG_WORKING_REGISTER_ALIAS_ADDR  12'hFD8
`define DOAG_BSR_ADDR   12'hFD9
// register bus byte offsets
`define DOAG_APB_CTRL   12'h000
`define DOAG_APB_BSR    12'h004
`define DOAG_APB_WORKING_REGISTER_ALIAS   12'h008
`define DOAG_APB_PTR0   12'h00C
`define DOAG_APB_PTR1   12'h010
`define DOAG_APB_PTR2   12'h014
`define DOAG_APB_STAT   12'h018
`define DOAG_CTRL_XEN   0
// reset values
`define DOAG_XEN_RST    1'b0
`define DOAG_BSR_RST    4'h0
`define DOAG_WORKING_REGISTER_ALIAS_RST   8'h00
`define DOAG_PTR_RST    12'h000
`endif

// [include/doag_pkg.sv]
// shared types and address helper of the operand address generator
`include "doag_params.svh"
`default_nettype none
package doag_pkg;
  typedef enum logic [2:0] {
    CL_INHERENT = 3'b000,
    CL_LITERAL  = 3'b001,
    CL_BYTE     = 3'b010,
    CL_BIT      = 3'b011,
    CL_MOVE     = 3'b100,
    CL_CONTROL  = 3'b101
  } doag_class_e;
  typedef enum logic [2:0] {
    MD_NONE     = 3'b000,
    MD_LITERAL  = 3'b001,
    MD_BANKED   = 3'b010,
    MD_ACCESS   = 3'b011,
    MD_FULL     = 3'b100,
    MD_INDIRECT = 3'b101,
    MD_INDEXED  = 3'b110
  } doag_mode_e;
  typedef logic [`DOAG_NPTR-1:0][`DOAG_ADDR_W-1:0] doag_ptrs_t;
  typedef struct packed {
    doag_ptrs_t ptr;
  } doag_ptr_s;
  typedef struct packed {
    logic                    xen;
    logic [3:0]              bank_select_register;
    logic [7:0]              working_register_alias;
    logic                    res_valid;
    doag_mode_e              mode;
    logic                    mem;
    logic [`DOAG_ADDR_W-1:0] src;
    logic [`DOAG_ADDR_W-1:0] dst;
    logic                    dst_w;
    logic [7:0]              lit;
    logic [`DOAG_TGT_W-1:0]  tgt;
    logic                    tgt_vld;
    logic [7:0]              rd_data;
    logic [15:0]             op_cnt;
  } doag_core_s;
  function automatic logic [`DOAG_ADDR_W-1:0] doag_vaddr(
    input logic [1:0] idx,
    input logic [2:0] kind);
    return {`DOAG_VOP_TAG, idx, kind};
  endfunction
endpackage
`default_nettype wire

// [core/doag_ptr_bank.sv]
// pointer registers with bus, special-register and auto-update write paths
`include "doag_params.svh"
`default_nettype none
module doag_ptr_bank (
  // clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    sys_rst_in,
  // register bus write
  input  wire logic                    bus_wr_in,
  input  wire logic [1:0]              bus_idx_in,
  input  wire logic [`DOAG_ADDR_W-1:0] bus_data_in,
  // data-side special register write
  input  wire logic                    sfr_wr_in,
  input  wire logic [`DOAG_ADDR_W-1:0] sfr_addr_in,
  input  wire logic [7:0]              sfr_data_in,
  // automatic update from a virtual operand access
  input  wire logic                    upd_en_in,
  input  wire logic [1:0]              upd_idx_in,
  input  wire logic [`DOAG_ADDR_W-1:0] upd_val_in,
  // pointer values
  output doag_pkg::doag_ptrs_t         ptr_out
);
  doag_pkg::doag_ptr_s st_r;
  doag_pkg::doag_ptr_s st_nxt;

  // later writes win: the update of the running access is the newest intent
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < `DOAG_NPTR; i++) begin
      if (bus_wr_in && bus_idx_in == 2'(i))
        st_nxt.ptr[i] = bus_data_in;
      if (sfr_wr_in && sfr_addr_in ==
          doag_pkg::doag_vaddr(2'(i), `DOAG_VK_PTR_LO))
        st_nxt.ptr[i][7:0] = sfr_data_in;
      if (sfr_wr_in && sfr_addr_in ==
          doag_pkg::doag_vaddr(2'(i), `DOAG_VK_PTR_HI))
        st_nxt.ptr[i][11:8] = sfr_data_in[3:0];
      if (upd_en_in && upd_idx_in == 2'(i))
        st_nxt.ptr[i] = upd_val_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      st_r <= '{ptr: {`DOAG_NPTR{`DOAG_PTR_RST}}};
    else
      st_r <= st_nxt;
  end

  assign ptr_out = st_r.ptr;
endmodule
`default_nettype wire

// [core/doag_ind_resolve.sv]
// maps a virtual operand address onto a pointer and its update
`include "doag_params.svh"
`default_nettype none
module doag_ind_resolve (
  // address to resolve and operands
  input  wire logic [`DOAG_ADDR_W-1:0] addr_in,
  input  wire doag_pkg::doag_ptrs_t    ptr_in,
  input  wire logic [7:0]              working_register_alias_in,
  // resolved access
  output logic [`DOAG_ADDR_W-1:0]      addr_out,
  output logic                         hit_out,
  // pointer update request
  output logic                         upd_out,
  output logic [1:0]                   idx_out,
  output logic [`DOAG_ADDR_W-1:0]      upd_val_out
);
  logic [2:0]              kind;
  logic [`DOAG_ADDR_W-1:0] cur;
  logic [`DOAG_ADDR_W-1:0] inc;

  always_comb begin
    kind        = addr_in[2:0];
    idx_out     = addr_in[4:3];
    cur         = (idx_out < 2'(`DOAG_NPTR)) ? ptr_in[idx_out] : '0;
    inc         = cur + 12'h001;
    hit_out     = addr_in[11:5] == `DOAG_VOP_TAG &&
                  idx_out < 2'(`DOAG_NPTR) && kind <= `DOAG_VK_PLUSW;
    addr_out    = addr_in;
    upd_out     = 1'b0;
    upd_val_out = cur;
    if (hit_out) begin
      case (kind)
        `DOAG_VK_POSTINC: begin
          addr_out    = cur;
          upd_out     = 1'b1;
          upd_val_out = inc;
        end
        `DOAG_VK_POSTDEC: begin
          addr_out    = cur;
          upd_out     = 1'b1;
          upd_val_out = cur - 12'h001;
        end
        `DOAG_VK_PREINC: begin
          addr_out    = inc;
          upd_out     = 1'b1;
          upd_val_out = inc;
        end
        `DOAG_VK_PLUSW:
          addr_out = cur + {{4{working_register_alias_in[7]}}, working_register_alias_in};
        default:
          addr_out = cur;
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/doag_top.sv]
// operand address generator: decode, banking, indexing, pointers, apb
//
// The implementer's own choices: the address map and register access over APB.
`include "doag_params.svh"
`default_nettype none
module doag_top (
  // clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    sys_rst_in,
  // apb slave
  input  wire logic                    apb_psel_in,
  input  wire logic                    apb_penable_in,
  input  wire logic                    apb_pwrite_in,
  input  wire logic [11:0]             apb_paddr_in,
  input  wire logic [31:0]             apb_pwdata_in,
  output logic [31:0]                  apb_prdata_out,
  output logic                         apb_pready_out,
  output logic                         apb_pslverr_out,
  // instruction decoder request
  input  wire logic                    op_valid_in,
  input  wire doag_pkg::doag_class_e   op_class_in,
  input  wire logic [15:0]             op_word_in,
  input  wire logic [15:0]             op_word2_in,
  input  wire logic                    op_dest_w_in,
  // special register access from the data path
  input  wire logic                    sfr_wr_in,
  input  wire logic [`DOAG_ADDR_W-1:0] sfr_addr_in,
  input  wire logic [7:0]              sfr_data_in,
  input  wire logic [`DOAG_ADDR_W-1:0] sfr_rd_addr_in,
  output logic [7:0]                   sfr_rd_data_out,
  // resolved operand
  output logic                         res_valid_out,
  output doag_pkg::doag_mode_e         res_mode_out,
  output logic                         res_mem_out,
  output logic [`DOAG_ADDR_W-1:0]      res_src_addr_out,
  output logic [`DOAG_ADDR_W-1:0]      res_dst_addr_out,
  output logic                         res_dst_w_out,
  output logic [7:0]                   res_lit_out,
  output logic [`DOAG_TGT_W-1:0]       res_tgt_out,
  output logic                         res_tgt_valid_out,
  // configuration state
  output logic                         xen_out
);
  //--------------------------------------------------------------------------
  // decode helpers
  //--------------------------------------------------------------------------
  function automatic logic [`DOAG_ADDR_W-1:0] doag_direct(
    input logic       a,
    input logic [7:0] f,
    input logic [3:0] bank_select_register);
    if (a)
      return {bank_select_register, f};
    else if (f < `DOAG_ACC_SPLIT)
      return {`DOAG_ACC_LO, f};
    else
      return {`DOAG_ACC_HI, f};
  endfunction

  // returns {hit, register index}
  function automatic logic [3:0] doag_apb_sel(input logic [11:0] addr);
    if (addr == `DOAG_APB_CTRL)
      return {1'b1, 3'h0};
    else if (addr == `DOAG_APB_BSR)
      return {1'b1, 3'h1};
    else if (addr == `DOAG_APB_WORKING_REGISTER_ALIAS)
      return {1'b1, 3'h2};
    else if (addr == `DOAG_APB_PTR0)
      return {1'b1, 3'h3};
    else if (addr == `DOAG_APB_PTR1)
      return {1'b1, 3'h4};
    else if (addr == `DOAG_APB_PTR2)
      return {1'b1, 3'h5};
    else if (addr == `DOAG_APB_STAT)
      return {1'b1, 3'h6};
    else
      return 4'h0;
  endfunction

  //--------------------------------------------------------------------------
  // state and wires
  //--------------------------------------------------------------------------
  doag_pkg::doag_core_s    st_r;
  doag_pkg::doag_core_s    st_nxt;
  doag_pkg::doag_ptrs_t    ptr_w;
  logic [7:0]              f;
  logic                    a_bit;
  logic                    d_bit;
  logic                    is_fo;
  logic                    idx_md;
  logic [`DOAG_ADDR_W-1:0] base_addr;
  logic [`DOAG_ADDR_W-1:0] fo_addr;
  doag_pkg::doag_mode_e    fo_mode;
  logic [`DOAG_ADDR_W-1:0] rs_addr;
  logic                    rs_hit;
  logic                    rs_upd;
  logic [1:0]              rs_idx;
  logic [`DOAG_ADDR_W-1:0] rs_val;
  logic                    upd_en;
  logic [3:0]              wr_sel;
  logic [3:0]              rd_sel;
  logic                    apb_acc;
  logic                    apb_wr;
  logic                    ptr_bus_wr;

  //--------------------------------------------------------------------------
  // file-operand address forming
  //--------------------------------------------------------------------------
  always_comb begin
    f      = op_word_in[7:0];
    a_bit  = op_word_in[`DOAG_OP_A_BIT];
    d_bit  = op_word_in[`DOAG_OP_D_BIT];
    is_fo  = op_valid_in &&
             (op_class_in == doag_pkg::CL_BYTE ||
              op_class_in == doag_pkg::CL_BIT);
    // only the third pointer gains the indexed form in extended mode
    idx_md = is_fo && st_r.xen && !a_bit && f <= `DOAG_IDX_MAX;
    if (idx_md)
      base_addr = ptr_w[`DOAG_IDX_PTR] + {4'h0, f};
    else
      base_addr = doag_direct(a_bit, f, st_r.bank_select_register);
    fo_addr = idx_md ? base_addr : rs_addr;
    if (idx_md)
      fo_mode = doag_pkg::MD_INDEXED;
    else if (rs_hit)
      fo_mode = doag_pkg::MD_INDIRECT;
    else if (a_bit)
      fo_mode = doag_pkg::MD_BANKED;
    else
      fo_mode = doag_pkg::MD_ACCESS;
    // the first two pointers resolve the same way in either mode
    upd_en = is_fo && !idx_md && rs_upd;
  end

  doag_ind_resolve u_resolve (
    .addr_in     (base_addr),
    .ptr_in      (ptr_w),
    .working_register_alias_in     (st_r.working_register_alias),
    .addr_out    (rs_addr),
    .hit_out     (rs_hit),
    .upd_out     (rs_upd),
    .idx_out     (rs_idx),
    .upd_val_out (rs_val)
  );

  //--------------------------------------------------------------------------
  // apb decode
  //--------------------------------------------------------------------------
  always_comb begin
    apb_acc    = apb_psel_in && apb_penable_in;
    wr_sel     = doag_apb_sel(apb_paddr_in);
    rd_sel     = wr_sel;
    apb_wr     = apb_acc && apb_pwrite_in && wr_sel[3];
    ptr_bus_wr = apb_wr && wr_sel[2:0] >= 3'h3 && wr_sel[2:0] <= 3'h5;
    apb_prdata_out = 32'h0000_0000;
    if (rd_sel[3]) begin
      case (rd_sel[2:0])
        3'h0: apb_prdata_out = {31'h0000_0000, st_r.xen};
        3'h1: apb_prdata_out = {28'h000_0000, st_r.bank_select_register};
        3'h2: apb_prdata_out = {24'h00_0000, st_r.working_register_alias};
        3'h3: apb_prdata_out = {20'h0_0000, ptr_w[0]};
        3'h4: apb_prdata_out = {20'h0_0000, ptr_w[1]};
        3'h5: apb_prdata_out = {20'h0_0000, ptr_w[2]};
        3'h6: apb_prdata_out = {st_r.op_cnt, 13'h0000, st_r.mode};
        default: apb_prdata_out = 32'h0000_0000;
      endcase
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign apb_pready_out  = 1'b1;
  assign apb_pslverr_out = apb_acc && !wr_sel[3];

  doag_ptr_bank u_ptrs (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .bus_wr_in   (ptr_bus_wr),
    .bus_idx_in  (2'(wr_sel[2:0] - 3'h3)),
    .bus_data_in (apb_pwdata_in[`DOAG_ADDR_W-1:0]),
    .sfr_wr_in   (sfr_wr_in),
    .sfr_addr_in (sfr_addr_in),
    .sfr_data_in (sfr_data_in),
    .upd_en_in   (upd_en),
    .upd_idx_in  (rs_idx),
    .upd_val_in  (rs_val),
    .ptr_out     (ptr_w)
  );

  //--------------------------------------------------------------------------
  // operand result and configuration state
  //--------------------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.res_valid = op_valid_in;
    st_nxt.tgt_vld   = 1'b0;
    if (apb_wr && wr_sel[2:0] == 3'h0)
      st_nxt.xen = apb_pwdata_in[`DOAG_CTRL_XEN];
    if (apb_wr && wr_sel[2:0] == 3'h1)
      st_nxt.bank_select_register = apb_pwdata_in[3:0];
    if (apb_wr && wr_sel[2:0] == 3'h2)
      st_nxt.working_register_alias = apb_pwdata_in[7:0];
    if (sfr_wr_in && sfr_addr_in == `DOAG_BSR_ADDR)
      st_nxt.bank_select_register = sfr_data_in[3:0];
    if (sfr_wr_in && sfr_addr_in == `DOAG_WORKING_REGISTER_ALIAS_ADDR)
      st_nxt.working_register_alias = sfr_data_in;
    if (op_valid_in) begin
      st_nxt.op_cnt = st_r.op_cnt + 16'h0001;
      st_nxt.mem    = 1'b0;
      st_nxt.dst_w  = op_dest_w_in;
      case (op_class_in)
        doag_pkg::CL_INHERENT:
          st_nxt.mode = doag_pkg::MD_NONE;
        doag_pkg::CL_LITERAL: begin
          st_nxt.mode = doag_pkg::MD_LITERAL;
          st_nxt.lit  = op_word_in[7:0];
        end
        doag_pkg::CL_CONTROL: begin
          // program targets never pass the data-side banking logic
          st_nxt.mode    = doag_pkg::MD_LITERAL;
          st_nxt.tgt     = {op_word2_in[11:0], op_word_in[7:0]};
          st_nxt.tgt_vld = 1'b1;
        end
        doag_pkg::CL_MOVE: begin
          st_nxt.mode  = doag_pkg::MD_FULL;
          st_nxt.mem   = 1'b1;
          st_nxt.src   = op_word_in[11:0];
          st_nxt.dst   = op_word2_in[11:0];
          st_nxt.dst_w = 1'b0;
        end
        doag_pkg::CL_BYTE: begin
          st_nxt.mode  = fo_mode;
          st_nxt.mem   = 1'b1;
          st_nxt.src   = fo_addr;
          st_nxt.dst   = fo_addr;
          st_nxt.dst_w = !d_bit;
        end
        doag_pkg::CL_BIT: begin
          st_nxt.mode  = fo_mode;
          st_nxt.mem   = 1'b1;
          st_nxt.src   = fo_addr;
          st_nxt.dst   = fo_addr;
          st_nxt.dst_w = 1'b0;
        end
        default:
          st_nxt.mode = doag_pkg::MD_NONE;
      endcase
    end
    if (sfr_rd_addr_in == `DOAG_WORKING_REGISTER_ALIAS_ADDR)
      st_nxt.rd_data = st_r.working_register_alias;
    else if (sfr_rd_addr_in == `DOAG_BSR_ADDR)
      st_nxt.rd_data = {4'h0, st_r.bank_select_register};
    else if (sfr_rd_addr_in[11:5] == `DOAG_VOP_TAG &&
             sfr_rd_addr_in[4:3] < 2'(`DOAG_NPTR) &&
             sfr_rd_addr_in[2:0] == `DOAG_VK_PTR_LO)
      st_nxt.rd_data = ptr_w[sfr_rd_addr_in[4:3]][7:0];
    else if (sfr_rd_addr_in[11:5] == `DOAG_VOP_TAG &&
             sfr_rd_addr_in[4:3] < 2'(`DOAG_NPTR) &&
             sfr_rd_addr_in[2:0] == `DOAG_VK_PTR_HI)
      st_nxt.rd_data = {4'h0, ptr_w[sfr_rd_addr_in[4:3]][11:8]};
    else
      st_nxt.rd_data = 8'h00;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_r      <= '0;
      st_r.xen  <= `DOAG_XEN_RST;
      st_r.bank_select_register  <= `DOAG_BSR_RST;
      st_r.working_register_alias <= `DOAG_WORKING_REGISTER_ALIAS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_valid_out     = st_r.res_valid;
  assign res_mode_out      = st_r.mode;
  assign res_mem_out       = st_r.mem;
  assign res_src_addr_out  = st_r.src;
  assign res_dst_addr_out  = st_r.dst;
  assign res_dst_w_out     = st_r.dst_w;
  assign res_lit_out       = st_r.lit;
  assign res_tgt_out       = st_r.tgt;
  assign res_tgt_valid_out = st_r.tgt_vld;
  assign sfr_rd_data_out   = st_r.rd_data;
  assign xen_out           = st_r.xen;

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_fo_plain;
    is_fo && !idx_md && !sfr_wr_in && !ptr_bus_wr;
  endsequence

  property p_ptr0_postinc;
    logic [11:0] p;
    (s_fo_plain ##0
     base_addr == doag_pkg::doag_vaddr(2'h0, `DOAG_VK_POSTINC),
     p = ptr_w[0])
    |=> res_src_addr_out == p && ptr_w[0] == p + 12'h001;
  endproperty

  property p_ptr1_preinc;
    logic [11:0] p;
    (s_fo_plain ##0
     base_addr == doag_pkg::doag_vaddr(2'h1, `DOAG_VK_PREINC),
     p = ptr_w[1])
    |=> res_src_addr_out == p + 12'h001 && ptr_w[1] == p + 12'h001;
  endproperty

  chk_inherent_no_mem: assert property (
    op_valid_in && op_class_in == doag_pkg::CL_INHERENT
    |=> res_valid_out && !res_mem_out && res_mode_out == doag_pkg::MD_NONE)
    else $error("inherent operation produced a data address");
  chk_literal_value: assert property (
    op_valid_in && op_class_in == doag_pkg::CL_LITERAL
    |=> res_lit_out == $past(op_word_in[7:0]))
    else $error("literal not taken from the opcode");
  chk_control_target: assert property (
    op_valid_in && op_class_in == doag_pkg::CL_CONTROL
    |=> res_tgt_valid_out ##1 !res_tgt_valid_out || $past(op_valid_in))
    else $error("program target strobe wrong");
  chk_bank_concat: assert property (
    is_fo && a_bit && st_r.bank_select_register != `DOAG_ACC_HI
    |=> res_src_addr_out == {$past(st_r.bank_select_register), $past(f)})
    else $error("banked address not formed from bank select");
  chk_access_bank: assert property (
    is_fo && !a_bit && !st_r.xen && f < `DOAG_ACC_SPLIT
    |=> res_src_addr_out == {`DOAG_ACC_LO, $past(f)})
    else $error("access bank address wrong");
  chk_full_move: assert property (
    op_valid_in && op_class_in == doag_pkg::CL_MOVE
    |=> res_src_addr_out == $past(op_word_in[11:0]) &&
        res_dst_addr_out == $past(op_word2_in[11:0]))
    else $error("full-address move altered");
  chk_dest_select: assert property (
    op_valid_in && op_class_in == doag_pkg::CL_BYTE
    |=> res_dst_w_out == !$past(d_bit))
    else $error("destination select inverted");
  chk_indexed_addr: assert property (
    is_fo && st_r.xen && !a_bit && f <= `DOAG_IDX_MAX
    |=> res_mode_out == doag_pkg::MD_INDEXED &&
        res_src_addr_out == $past(ptr_w[2]) + {4'h0, $past(f)})
    else $error("indexed offset address wrong");
  chk_ext_direct: assert property (
    is_fo && st_r.xen && !a_bit && f > `DOAG_IDX_MAX &&
    f < `DOAG_ACC_SPLIT
    |=> res_src_addr_out == {`DOAG_ACC_LO, $past(f)})
    else $error("high file address left direct mode");
  chk_ptr_postinc: assert property (p_ptr0_postinc)
    else $error("post-increment walk wrong");
  chk_ptr_preinc: assert property (p_ptr1_preinc)
    else $error("pre-increment walk wrong");
  // reckoned from the map itself, not from the decode function
  chk_apb_unmapped: assert property (
    apb_acc |-> apb_pslverr_out == (apb_paddr_in[1:0] != 2'b00 ||
                                    apb_paddr_in > `DOAG_APB_STAT))
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// [sim/doag_dp_model.sv]
// data-path model: turns a byte store request into one sfr write pulse
`default_nettype none
module doag_dp_model (
  // clock and store request
  input  wire logic        sys_clk_in,
  input  wire logic        st_req_in,
  input  wire logic [11:0] st_addr_in,
  input  wire logic [7:0]  st_data_in,
  // special register write
  output logic             sfr_wr_out,
  output logic [11:0]      sfr_addr_out,
  output logic [7:0]       sfr_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sfr_wr_out = 1'b0;
  initial sfr_addr_out = 12'h000;
  initial sfr_data_out = 8'h00;
  // idle lines toggle so a stale address is never mistaken for a store
  always @(posedge sys_clk_in) begin
    sfr_wr_out <= st_req_in;
    sfr_addr_out <= st_req_in ? st_addr_in : ~sfr_addr_out;
    sfr_data_out <= st_req_in ? st_data_in : ~sfr_data_out;
  end
endmodule
`default_nettype wire

// [sim/doag_top_tb.sv]
// self-checking bench of the operand address generator
`default_nettype none
module doag_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic x; logic [2:0] c; logic [15:0] w; logic [15:0] v;
    logic d; logic [2:0] m; logic [11:0] s; logic e;
  } doag_row_s;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic ov = 1'b0, dw = 1'b0, sr = 1'b0, sfw, rdy, err, ae, rv, mem;
  logic sdw, tv, xen;
  logic [11:0] pad = 12'h000, sa = 12'h000, ra = 12'h000, sfa, src, dst;
  logic [31:0] pwd = 32'h0, q, prd;
  logic [15:0] w1 = 16'h0, w2 = 16'h0;
  logic [7:0] sd = 8'h00, sfd, rd, lit;
  logic [19:0] tgt;
  doag_pkg::doag_class_e cl = doag_pkg::CL_INHERENT;
  doag_pkg::doag_mode_e md;
  int errors = 0, checks_done = 0, cyc = 0;
  doag_row_s rows [13] = '{
    '{1'h0,3'h0,16'h0000,16'h0,1'h1,3'h0,12'h000,1'h1},
    '{1'h0,3'h1,16'h0E7F,16'h0,1'h1,3'h1,12'h000,1'h1},
    '{1'h0,3'h2,16'h0334,16'h0,1'h0,3'h2,12'h534,1'h0},
    '{1'h0,3'h2,16'h0034,16'h0,1'h0,3'h3,12'h034,1'h1},
    '{1'h0,3'h2,16'h0290,16'h0,1'h0,3'h3,12'hF90,1'h0},
    '{1'h0,3'h3,16'h0110,16'h0,1'h1,3'h2,12'h510,1'h0},
    '{1'h1,3'h4,16'h0123,16'hF456,1'h0,3'h4,12'h123,1'h0},
    '{1'h1,3'h2,16'h025F,16'h0,1'h0,3'h6,12'h25F,1'h0},
    '{1'h1,3'h2,16'h0260,16'h0,1'h0,3'h3,12'h060,1'h0},
    '{1'h1,3'h2,16'h0310,16'h0,1'h0,3'h2,12'h510,1'h0},
    '{1'h1,3'h1,16'h0E12,16'h0,1'h1,3'h1,12'h000,1'h1},
    '{1'h1,3'h2,16'h02C0,16'h0,1'h0,3'h5,12'h0FF,1'h0},
    '{1'h0,3'h2,16'h02D4,16'h0,1'h0,3'h5,12'h1FE,1'h0}};
  always #2 clk = ~clk;
  doag_top DUT (.sys_clk_in(clk), .sys_rst_in(rst), .apb_psel_in(psel),
    .apb_penable_in(pen), .apb_pwrite_in(pwr), .apb_paddr_in(pad),
    .apb_pwdata_in(pwd), .apb_prdata_out(prd), .apb_pready_out(rdy),
    .apb_pslverr_out(err), .op_valid_in(ov), .op_class_in(cl),
    .op_word_in(w1), .op_word2_in(w2), .op_dest_w_in(dw),
    .sfr_wr_in(sfw), .sfr_addr_in(sfa), .sfr_data_in(sfd),
    .sfr_rd_addr_in(ra), .sfr_rd_data_out(rd), .res_valid_out(rv),
    .res_mode_out(md), .res_mem_out(mem), .res_src_addr_out(src),
    .res_dst_addr_out(dst), .res_dst_w_out(sdw), .res_lit_out(lit),
    .res_tgt_out(tgt), .res_tgt_valid_out(tv), .xen_out(xen));
  doag_dp_model PM (.sys_clk_in(clk), .st_req_in(sr), .st_addr_in(sa),
    .st_data_in(sd), .sfr_wr_out(sfw), .sfr_addr_out(sfa),
    .sfr_data_out(sfd));
  task automatic close_out();
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one idle cycle between transfers keeps psel from being driven twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd;
    ae = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic op(input logic [2:0] c, input logic [15:0] a,
                    input logic [15:0] b, input logic d);
    @(posedge clk);
    ov <= 1'b1;
    cl <= doag_pkg::doag_class_e'(c);
    w1 <= a;
    w2 <= b;
    dw <= d;
    @(posedge clk);
    ov <= 1'b0;
    #1 chk(rv, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    apb(1'b1, 12'h004, 32'h5);
    apb(1'b1, 12'h008, 32'hFE);
    apb(1'b1, 12'h00C, 32'hFF);
    apb(1'b1, 12'h010, 32'h10);
    apb(1'b1, 12'h014, 32'h200);
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {31'h0, rows[i].x});
      op(rows[i].c, rows[i].w, rows[i].v, rows[i].d);
      chk(md, rows[i].m);
      chk(mem, rows[i].m > 3'h1);
      if (rows[i].m > 3'h1) chk(src, rows[i].s);
      chk(sdw, rows[i].e);
      chk(xen, rows[i].x);
      if (rows[i].c == 3'h1) chk(lit, rows[i].w[7:0]);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk(q, 32'h200);
    op(3'h2, 16'h00C1, 16'h0, 1'b0);
    chk(src, 12'h0FF);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h100);
    op(3'h2, 16'h00C2, 16'h0, 1'b0);
    chk(src, 12'h100);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'hFF);
    op(3'h2, 16'h00CB, 16'h0, 1'b0);
    chk(src, 12'h011);
    op(3'h4, 16'h0123, 16'hF456, 1'b0);
    chk(dst, 12'h456);
    op(3'h5, 16'h0034, 16'hF123, 1'b0);
    chk(tgt, 20'h12334);
    chk(tv, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    chk(q, 32'h0012_0001);
    chk(ae, 1'b0);
    @(posedge clk);
    sr <= 1'b1;
    sa <= 12'hFC5;
    sd <= 8'h40;
    ra <= 12'hFD9;
    @(posedge clk);
    sr <= 1'b0;
    #1 chk(rd, 8'h05);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h40);
    apb(1'b1, 12'h01C, 32'h1);
    chk(ae, 1'b1);
    // mid-run reset must clear bank select and the first pointer again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(rv, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
